// ==== pm_device.sv ====
/*
 * power state and wake controller: normal, light and deep sleep states,
 * wake source tracking, wake pin and wake interrupt, phy power-down modes.
 * assumes a host on pm_if keeps access rules while ready is clear, and
 * raw line and wake-frame detector levels from outside this clock domain.
 */
`timescale 1ns/1ps
`include "pm_regs.svh"
module pm_device (
    input  wire logic   clk,            // 25 mhz clock
    input  wire logic   rst_b,          // synchronous reset, active low
    pm_if.device        bus,            // register port
    input  wire logic   line_energy_present, // raw line energy level
    input  wire logic   frame_match,    // raw wake frame or packet detected
    output logic        wake_pin,       // external wake output, active high
    output logic        wake_irq,       // host interrupt
    output logic        mac_clk_en,     // mac and host interface clock on
    output logic        rx_pm_clk_en,   // rx power management clock on
    output logic        int_clk_en,     // internal clock on
    output logic        phy_powered,    // phy analog section powered
    output logic        phy_tx_en       // phy may transmit
);
    pm_pkg::power_state_type state;
    logic [1:0]  wake_source_status;
    logic        ready, read_seen;
    logic        wake_pin_enable, wake_pulse_select, wake_frame_enable, energy_detect_enable;
    logic        irq_stat_wake, irq_mask_wake;
    logic        phy_gen_pdown, phy_energy_power_down, phy_int_energy, phy_int_en;
    logic [1:0]  energy_sync, frame_sync;
    logic        energy_prev;
    logic [31:0] pulse_cnt;
    logic        pulse_live;
    logic        acc, wr_ok, wake_event, wake_write, next_ack;
    logic [31:0] next_rdata;

    // inputs from outside the clock domain pass two flops
    always_ff @(posedge clk)
    begin
        energy_sync <= {energy_sync[0], line_energy_present};
        frame_sync  <= {frame_sync[0], frame_match};
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // access qualification
    assign acc        = bus.req & ~bus.ack;
    assign wake_write = acc & bus.wr & hit(bus.addr, `PM_WAKE_TEST_ADDR)
                        & (state != pm_pkg::normal_state);
    assign wr_ok      = acc & bus.wr & ready & read_seen;
    assign wake_event = (wake_source_status == `PM_SRC_FRAME & wake_frame_enable)
                      | (wake_source_status == `PM_SRC_ENERGY & energy_detect_enable);

    // power state machine
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= pm_pkg::normal_state;
            ready <= 1'b1;
        end
        else
        begin
            case (state)
                pm_pkg::normal_state:
                begin
                    if (wr_ok && hit(bus.addr, `PM_CTRL_ADDR))
                    begin
                        if (bus.wdata[`PM_STATE_LO +: 2] == `PM_STATE_LIGHT)
                        begin
                            state <= pm_pkg::light_sleep_state;
                            ready <= 1'b0;
                        end
                        else if (bus.wdata[`PM_STATE_LO +: 2] == `PM_STATE_DEEP)
                        begin
                            state <= pm_pkg::deep_sleep_state;
                            ready <= 1'b0;
                        end
                    end
                end
                pm_pkg::light_sleep_state, pm_pkg::deep_sleep_state:
                begin
                    if (wake_write)
                    begin
                        state <= pm_pkg::normal_state;
                        ready <= 1'b1;
                    end
                end
                default:
                    state <= pm_pkg::normal_state;
            endcase
        end
    end

    // first read after reset or wake unlocks writes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            read_seen <= 1'b0;
        else if (wake_write || (wr_ok && hit(bus.addr, `PM_CTRL_ADDR)
                 && bus.wdata[`PM_STATE_LO +: 2] != `PM_STATE_NORMAL))
            read_seen <= 1'b0;
        else if (acc && !bus.wr)
            read_seen <= 1'b1;
    end

    // control register fields, kept across sleep
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wake_pin_enable      <= 1'b0;
            wake_pulse_select    <= 1'b0;
            wake_frame_enable    <= 1'b0;
            energy_detect_enable <= 1'b0;
        end
        else if (wr_ok && hit(bus.addr, `PM_CTRL_ADDR))
        begin
            wake_pin_enable      <= bus.wdata[`PM_PIN_EN_BIT];
            wake_pulse_select    <= bus.wdata[`PM_PULSE_SEL_BIT];
            wake_frame_enable    <= bus.wdata[`PM_FRAME_EN_BIT];
            energy_detect_enable <= bus.wdata[`PM_ENERGY_DETECT_ENABLE_BIT];
        end
    end

    // wake source: detection sets, host write of 1s clears, set wins
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wake_source_status <= `PM_SRC_NONE;
        else if (state == pm_pkg::light_sleep_state && frame_sync[1])
            wake_source_status <= `PM_SRC_FRAME;
        else if (state == pm_pkg::deep_sleep_state && energy_sync[1])
            wake_source_status <= `PM_SRC_ENERGY;
        else if (wr_ok && hit(bus.addr, `PM_CTRL_ADDR))
            wake_source_status <= wake_source_status & ~bus.wdata[`PM_SRC_LO +: 2];
    end

    // wake interrupt flag sticks while event active, then write-1-clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_stat_wake <= 1'b0;
        else if (wake_event)
            irq_stat_wake <= 1'b1;
        else if (wr_ok && hit(bus.addr, `PM_IRQ_STAT_ADDR) && bus.wdata[`PM_IRQ_WAKE_BIT])
            irq_stat_wake <= 1'b0;
    end

    // interrupt mask and phy control registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_mask_wake         <= 1'b0;
            phy_gen_pdown         <= 1'b0;
            phy_energy_power_down <= 1'b0;
            phy_int_en            <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (hit(bus.addr, `PM_IRQ_MASK_ADDR))
                irq_mask_wake <= bus.wdata[`PM_IRQ_WAKE_BIT];
            if (hit(bus.addr, `PM_PHY_CTRL_ADDR))
                phy_gen_pdown <= bus.wdata[`PM_PHY_PDOWN_BIT];
            if (hit(bus.addr, `PM_PHY_MODE_ADDR))
                phy_energy_power_down <= bus.wdata[`PM_PHY_EDPD_BIT];
            if (hit(bus.addr, `PM_PHY_INT_ADDR))
                phy_int_en <= bus.wdata[`PM_PHY_INT_ED_BIT];
        end
    end

    // phy energy-on flag: rising energy in power-down sets, read clears
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            energy_prev    <= 1'b0;
            phy_int_energy <= 1'b0;
        end
        else
        begin
            energy_prev <= energy_sync[1];
            if (phy_energy_power_down && energy_sync[1] && !energy_prev)
                phy_int_energy <= 1'b1;
            else if (acc && !bus.wr && hit(bus.addr, `PM_PHY_INT_ADDR))
                phy_int_energy <= 1'b0;
        end
    end

    // wake pin pulse timer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pulse_cnt  <= 32'h0;
            pulse_live <= 1'b0;
        end
        else if (!wake_event || !wake_pin_enable)
        begin
            pulse_cnt  <= 32'h0;
            pulse_live <= 1'b0;
        end
        else if (!pulse_live && pulse_cnt == 32'h0)
        begin
            pulse_cnt  <= 32'(`PM_PULSE_CYCLES);
            pulse_live <= 1'b1;
        end
        else if (pulse_live)
        begin
            // expiry parks the count at one so the same event never pulses twice
            if (pulse_cnt == 32'h1)
                pulse_live <= 1'b0;
            else
                pulse_cnt  <= pulse_cnt - 32'h1;
        end
    end

    // outputs: pin, interrupt and clock gating
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wake_pin     <= 1'b0;
            wake_irq     <= 1'b0;
            mac_clk_en   <= 1'b1;
            rx_pm_clk_en <= 1'b1;
            int_clk_en   <= 1'b1;
            phy_powered  <= 1'b1;
            phy_tx_en    <= 1'b1;
        end
        else
        begin
            wake_pin     <= wake_event & wake_pin_enable
                            & (wake_pulse_select ? pulse_live : 1'b1);
            wake_irq     <= (irq_stat_wake & irq_mask_wake)
                            | (phy_int_energy & phy_int_en);
            mac_clk_en   <= (state == pm_pkg::normal_state);
            rx_pm_clk_en <= (state != pm_pkg::deep_sleep_state);
            int_clk_en   <= (state != pm_pkg::deep_sleep_state);
            phy_powered  <= !phy_gen_pdown
                            && !(phy_energy_power_down && !energy_sync[1]);
            phy_tx_en    <= !phy_gen_pdown
                            && !(phy_energy_power_down && !energy_sync[1]);
        end
    end

    // read mux; in sleep only the control register answers with data
    always_comb
    begin
        next_ack   = acc;
        next_rdata = 32'h0;
        if (acc && !bus.wr && (ready || hit(bus.addr, `PM_CTRL_ADDR)))
        begin
            if (hit(bus.addr, `PM_CTRL_ADDR))
            begin
                next_rdata[`PM_READY_BIT]       = ready;
                next_rdata[`PM_PIN_EN_BIT]      = wake_pin_enable;
                next_rdata[`PM_PULSE_SEL_BIT]   = wake_pulse_select;
                next_rdata[`PM_SRC_LO +: 2]     = wake_source_status;
                next_rdata[`PM_FRAME_EN_BIT]    = wake_frame_enable;
                next_rdata[`PM_STATE_LO +: 2]   = (state == pm_pkg::light_sleep_state)
                    ? `PM_STATE_LIGHT : (state == pm_pkg::deep_sleep_state)
                    ? `PM_STATE_DEEP : `PM_STATE_NORMAL;
                next_rdata[`PM_ENERGY_DETECT_ENABLE_BIT]       = energy_detect_enable;
            end
            else if (hit(bus.addr, `PM_IRQ_STAT_ADDR))
                next_rdata[`PM_IRQ_WAKE_BIT] = irq_stat_wake;
            else if (hit(bus.addr, `PM_IRQ_MASK_ADDR))
                next_rdata[`PM_IRQ_WAKE_BIT] = irq_mask_wake;
            else if (hit(bus.addr, `PM_PHY_CTRL_ADDR))
                next_rdata[`PM_PHY_PDOWN_BIT] = phy_gen_pdown;
            else if (hit(bus.addr, `PM_PHY_MODE_ADDR))
                next_rdata[`PM_PHY_EDPD_BIT] = phy_energy_power_down;
            else if (hit(bus.addr, `PM_PHY_INT_ADDR))
                next_rdata[`PM_PHY_INT_ED_BIT] = phy_int_energy;
        end
    end

    // register answer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus.ack   <= 1'b0;
            bus.rdata <= 32'h0;
        end
        else
        begin
            bus.ack   <= next_ack;
            bus.rdata <= next_rdata;
        end
    end
endmodule

// ==== pm_host.sv ====
/*
 * host end: takes orders over avalon-mm with waitrequest and drives them
 * onto pm_if, honouring the ready and first-read rules of the device.
 * assumes one clock shared with the device.
 */
`timescale 1ns/1ps
`include "pm_regs.svh"
module pm_host (
    input  wire logic          clk,             // 25 mhz clock
    input  wire logic          rst_b,           // synchronous reset, active low
    pm_if.host                 bus,             // device register port
    input  wire logic [7:0]    avs_address,     // byte address of device register
    input  wire logic          avs_read,        // avalon read
    input  wire logic          avs_write,       // avalon write
    input  wire logic [31:0]   avs_writedata,   // avalon write data
    output logic [31:0]        avs_readdata,    // avalon read data
    output logic               avs_waitrequest, // avalon wait
    output logic               refused          // last access blocked, not ready
);
    pm_pkg::host_state_type hstate;
    logic        dev_ready;   // last seen device ready
    logic        allowed;

    // while not ready, only control reads and wake test writes go out
    assign allowed = dev_ready
                   || (avs_read && avs_address == `PM_CTRL_ADDR)
                   || (avs_write && avs_address == `PM_WAKE_TEST_ADDR);

    // request sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hstate          <= pm_pkg::host_idle;
            bus.req         <= 1'b0;
            bus.wr          <= 1'b0;
            bus.addr        <= 8'h0;
            bus.wdata       <= 32'h0;
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
            refused         <= 1'b0;
            dev_ready       <= 1'b0;
        end
        else
        begin
            case (hstate)
                pm_pkg::host_idle:
                begin
                    avs_waitrequest <= 1'b1;
                    if (avs_read || avs_write)
                    begin
                        if (allowed)
                        begin
                            bus.req   <= 1'b1;
                            bus.wr    <= avs_write;
                            bus.addr  <= avs_address;
                            bus.wdata <= avs_writedata;
                            hstate    <= pm_pkg::host_access;
                        end
                        else
                        begin
                            refused         <= 1'b1;
                            avs_readdata    <= 32'h0;
                            avs_waitrequest <= 1'b0;
                            hstate          <= pm_pkg::host_done;
                        end
                    end
                end
                pm_pkg::host_access:
                begin
                    if (bus.ack)
                    begin
                        bus.req         <= 1'b0;
                        refused         <= 1'b0;
                        avs_readdata    <= bus.rdata;
                        avs_waitrequest <= 1'b0;
                        hstate          <= pm_pkg::host_done;
                        if (!bus.wr && bus.addr == `PM_CTRL_ADDR)
                            dev_ready <= bus.rdata[`PM_READY_BIT];
                        else if (bus.wr && (bus.addr == `PM_WAKE_TEST_ADDR
                                 || (bus.addr == `PM_CTRL_ADDR
                                 && bus.wdata[`PM_STATE_LO +: 2] != `PM_STATE_NORMAL)))
                            dev_ready <= 1'b0;
                    end
                end
                pm_pkg::host_done:
                begin
                    avs_waitrequest <= 1'b1;
                    hstate          <= pm_pkg::host_idle;
                end
                default:
                    hstate <= pm_pkg::host_idle;
            endcase
        end
    end
endmodule

// ==== pm_if.sv ====
/*
 * register port between the host processor and the power controller.
 * assumes one shared clock; the device answers every access with ack.
 */
`timescale 1ns/1ps
interface pm_if;
    logic        req;     // access request, held until ack
    logic        wr;      // 1 write, 0 read
    logic [7:0]  addr;    // byte address
    logic [31:0] wdata;   // write data
    logic [31:0] rdata;   // read data, valid with ack
    logic        ack;     // one-cycle completion pulse

    modport device (input req, wr, addr, wdata, output rdata, ack);
    modport host   (output req, wr, addr, wdata, input rdata, ack);
endinterface

// ==== pm_pkg.sv ====
/*
 * shared types of the power state and wake control block.
 * assumes pm_regs.svh holds the numeric constants.
 */
package pm_pkg;
    typedef enum logic [1:0] {normal_state, light_sleep_state, deep_sleep_state} power_state_type;
    typedef enum logic [1:0] {host_idle, host_access, host_done} host_state_type;
endpackage

// ==== pm_regs.svh ====
/*
 * offsets, field positions, write mask, source and state codes and timing counts of the power state
 * and wake control block. assumes a 32-bit word-aligned register map.
 */
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// register byte addresses
`define PM_CTRL_ADDR        8'h54
`define PM_IRQ_STAT_ADDR    8'h58
`define PM_IRQ_MASK_ADDR    8'h5c
`define PM_WAKE_TEST_ADDR   8'h64
`define PM_PHY_CTRL_ADDR    8'h70
`define PM_PHY_MODE_ADDR    8'h74
`define PM_PHY_INT_ADDR     8'h78

// power management control fields
`define PM_READY_BIT        0
`define PM_PIN_EN_BIT       1
`define PM_PULSE_SEL_BIT    3
`define PM_FRAME_EN_BIT     9
`define PM_ENERGY_DETECT_ENABLE_BIT        14
`define PM_SRC_LO           4
`define PM_STATE_LO         12
`define PM_WR_MASK          32'h0000_420a

// wake source codes
`define PM_SRC_NONE         2'h0
`define PM_SRC_ENERGY       2'h1
`define PM_SRC_FRAME        2'h2

// power state codes
`define PM_STATE_NORMAL     2'h0
`define PM_STATE_LIGHT      2'h1
`define PM_STATE_DEEP       2'h2

// interrupt status and phy register fields
`define PM_IRQ_WAKE_BIT     17
`define PM_PHY_PDOWN_BIT    11
`define PM_PHY_EDPD_BIT     13
`define PM_PHY_INT_ED_BIT   1

// wake pulse length
`define PM_PULSE_MS         50
`define PM_CLK_KHZ          25000
`define PM_PULSE_CYCLES     (`PM_PULSE_MS * `PM_CLK_KHZ)

`endif

// ==== pm_sva.sv ====
/*
 * assertions on the pm_if port and the clock and phy enables.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "pm_regs.svh"
module pm_sva (
    input wire logic        clk,          // clock
    input wire logic        rst_b,        // reset, active low
    input wire logic        req,          // access request
    input wire logic        wr,           // write select
    input wire logic [7:0]  addr,         // byte address
    input wire logic [31:0] wdata,        // write data
    input wire logic [31:0] rdata,        // read data
    input wire logic        ack,          // completion pulse
    input wire logic        mac_clk_en,   // mac clock on
    input wire logic        rx_pm_clk_en, // rx pm clock on
    input wire logic        int_clk_en,   // internal clock on
    input wire logic        phy_powered,  // phy powered
    input wire logic        phy_tx_en     // phy may transmit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // handshake on the register port
    a_ack_follows: assert property (req && !ack |=> ack)
        else $error("ack missing after request");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_req_held: assert property (req && !ack |=> $stable({wr, addr, wdata}))
        else $error("request changed before ack");
    a_req_drop: assert property (ack |=> !req)
        else $error("request kept after ack");
    a_req_gap: assert property (ack |=> !ack ##1 !ack)
        else $error("requests closer than three cycles");
    // ready bit agrees with the state field; wake test write restores mac and internal clocks
    a_ready_state: assert property (ack && !wr && addr == `PM_CTRL_ADDR
        |-> rdata[`PM_READY_BIT] == (rdata[13:12] == `PM_STATE_NORMAL))
        else $error("ready and state disagree");
    a_wake_clk: assert property (ack && wr && addr == `PM_WAKE_TEST_ADDR
        |-> ##[1:3] (mac_clk_en && int_clk_en))
        else $error("no return to normal after wake write");
    // clock gating per state, and phy transmit off while unpowered
    a_light_clk: assert property (!mac_clk_en && int_clk_en |-> rx_pm_clk_en && phy_powered)
        else $error("light sleep gating wrong");
    a_deep_clk: assert property (!int_clk_en |-> !mac_clk_en && !rx_pm_clk_en)
        else $error("deep sleep gating wrong");
    a_tx_off: assert property (!phy_powered |-> !phy_tx_en)
        else $error("transmit while phy powered down");
endmodule

// ==== tb_top.sv ====
/*
 * testbench: drives the host over avalon-mm and the device line inputs,
 * compares against a field model of the control register.
 * assumes pm_regs.svh addresses and a 25 mhz clock.
 */
`timescale 1ns/1ps
`include "pm_regs.svh"
module tb_top;
    logic        clk;                 // bench clock
    logic        rst_b;               // reset, active low
    logic [7:0]  avs_address;         // master address
    logic        avs_read;            // master read
    logic        avs_write;           // master write
    logic [31:0] avs_writedata;       // master write data
    logic [31:0] avs_readdata;        // slave read data
    logic        avs_waitrequest;     // slave wait
    logic        line_energy_present; // line energy
    logic        frame_match;         // wake frame seen
    logic [6:0]  o;                   // device level outputs
    logic [31:0] rd;                  // last read data
    int          err_total;           // mismatches
    int          num_checks;          // comparisons
    int          seed;                // random seed
    int          m_en;                // model enables
    int          m_src;               // model wake source
    int          m_state;             // model power state

    pm_if bus();
    pm_device i_pm_device (.clk(clk), .rst_b(rst_b), .bus(bus),
        .line_energy_present(line_energy_present), .frame_match(frame_match),
        .wake_pin(o[0]), .wake_irq(o[1]), .phy_powered(o[2]), .mac_clk_en(o[3]),
        .rx_pm_clk_en(o[4]), .int_clk_en(o[5]), .phy_tx_en(o[6]));
    pm_host i_pm_host (.clk(clk), .rst_b(rst_b), .bus(bus), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .refused());
    pm_sva i_pm_sva (.clk(clk), .rst_b(rst_b), .req(bus.req), .wr(bus.wr),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack),
        .mac_clk_en(o[3]), .rx_pm_clk_en(o[4]), .int_clk_en(o[5]),
        .phy_powered(o[2]), .phy_tx_en(o[6]));

    // clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // compares of register data and of output levels
    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_lvl(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 40)
        begin
            chk_lvl("waitrequest", 1'b0, 1'b1);
            test_done();
        end
    endtask

    // bounded wait for an output level, then compare
    task automatic wait_lvl(input string n, input int i, input logic v);
        int k;
        for (k = 0; k < 60 && o[i] !== v; k++)
            @(posedge clk);
        chk_lvl(n, v, o[i]);
        if (o[i] !== v)
            test_done();
    endtask

    // control register read against the model
    task automatic rd_ctrl();
        logic [31:0] e;
        e = m_en | (m_src << 4) | (m_state << 12) | (m_state == 0);
        acc(1'b0, `PM_CTRL_ADDR, 32'h0);
        chk_val("ctrl", e, rd & 32'h0000_723b);
    endtask

    task automatic wr_ctrl(input logic [31:0] d);
        acc(1'b1, `PM_CTRL_ADDR, d);
        m_en = d & `PM_WR_MASK;
        m_src = m_src & ~((d >> 4) & 3);
        m_state = (d[13:12] != 2'h0) ? d[13:12] : m_state;
    endtask

    // irq status read, bit 17 compared
    task automatic rd_irq(input logic e);
        acc(1'b0, `PM_IRQ_STAT_ADDR, 32'h0);
        chk_lvl("irq_status", e, rd[17]);
    endtask

    // main sequence
    initial
    begin
        {rst_b, avs_read, avs_write, frame_match, line_energy_present} = 5'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        {seed, m_en, m_src, m_state, err_total, num_checks} = {56917, 0, 0, 0, 0, 0};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_ctrl();
        acc(1'b1, `PM_IRQ_MASK_ADDR, 32'h0002_0000);
        wr_ctrl(32'h0000_4202);
        rd_ctrl();
        // light sleep and frame wake
        wr_ctrl(32'h0000_5202);
        wait_lvl("mac_clk", 3, 1'b0);
        wait_lvl("rx_pm_clk", 4, 1'b1);
        rd_ctrl();
        frame_match <= 1'b1;
        m_src = 2;
        wait_lvl("wake_pin", 0, 1'b1);
        wait_lvl("wake_irq", 1, 1'b1);
        frame_match <= 1'b0;
        rd_ctrl();
        acc(1'b1, `PM_WAKE_TEST_ADDR, $random(seed));
        m_state = 0;
        rd_ctrl();
        repeat (20) @(posedge clk);
        chk_lvl("wake_pin", 1'b1, o[0]);
        acc(1'b1, `PM_IRQ_STAT_ADDR, 32'h0002_0000);
        rd_irq(1'b1);
        wr_ctrl(32'h0000_4232);
        wait_lvl("wake_pin", 0, 1'b0);
        acc(1'b1, `PM_IRQ_STAT_ADDR, 32'h0002_0000);
        rd_irq(1'b0);
        wait_lvl("wake_irq", 1, 1'b0);
        // deep sleep and energy wake
        acc(1'b1, `PM_PHY_MODE_ADDR, 32'h0000_2000);
        wr_ctrl(32'h0000_620a);
        wait_lvl("int_clk", 5, 1'b0);
        wait_lvl("phy_powered", 2, 1'b0);
        wait_lvl("phy_tx", 6, 1'b0);
        rd_ctrl();
        line_energy_present <= 1'b1;
        m_src = 1;
        wait_lvl("wake_pin", 0, 1'b1);
        wait_lvl("phy_powered", 2, 1'b1);
        rd_ctrl();
        acc(1'b1, `PM_WAKE_TEST_ADDR, $random(seed));
        m_state = 0;
        acc(1'b1, `PM_CTRL_ADDR, 32'h0);
        rd_ctrl();
        acc(1'b1, `PM_PHY_MODE_ADDR, 32'h0);
        acc(1'b0, `PM_PHY_INT_ADDR, 32'h0);
        chk_lvl("phy_int", 1'b1, rd[1]);
        wr_ctrl(32'h0000_0202);
        wait_lvl("wake_pin", 0, 1'b0);
        rd_ctrl();
        // phy general power-down
        acc(1'b1, `PM_PHY_CTRL_ADDR, 32'h0000_0800);
        wait_lvl("phy_powered", 2, 1'b0);
        acc(1'b1, `PM_PHY_CTRL_ADDR, 32'h0);
        wait_lvl("phy_powered", 2, 1'b1);
        test_done();
    end
endmodule
